/* File: verilog/dmup_host.sv */
`default_nettype none
module dmup_host (
  input  wire logic                         mclk,
  input  wire logic                         srst,
  input  wire logic                         ce,
  input  wire logic                         scheme_cfg,
  input  wire logic                         req,
  input  wire logic                         req_wr,
  input  wire logic [dmup_pkg::ADDR_W-1:0]  req_addr,
  input  wire logic [dmup_pkg::DATA_W-1:0]  req_wdata,
  output logic                              busy,
  output logic                              done,
  output logic [dmup_pkg::DATA_W-1:0]       rdata,
  dmup_if.host                              port
);
  import dmup_pkg::*;

  typedef enum logic [2:0] {
    DMUPH_IDLE,
    DMUPH_SETUP,
    DMUPH_ASSERT,
    DMUPH_WAIT,
    DMUPH_RELEASE
  } dmup_host_state_e;

  typedef struct packed {
    dmup_host_state_e   st;
    logic               scheme;
    logic               cs_n;
    logic [ADDR_W-1:0]  addr;
    logic               strobe_n;
    logic               dir;
    logic [DATA_W-1:0]  d_o;
    logic               d_oe;
    logic               wr;
    logic               done;
    logic [DATA_W-1:0]  rdata;
  } dmup_host_s;

  dmup_host_s state_r;
  dmup_host_s state_nxt;
  logic       hs_ready;

  // completion seen on the shared handshake pin, read per scheme
  assign hs_ready = (state_r.scheme == DATA_STROBE_SCHEME) ? ~port.handshake_out
                                                           : port.handshake_out;

  always_comb begin
    state_nxt      = state_r;
    state_nxt.done = 1'b0;
    case (state_r.st)
      DMUPH_IDLE: begin
        // scheme pin only changes between accesses
        state_nxt.scheme = scheme_cfg;
        if (req) begin
          state_nxt.st   = DMUPH_SETUP;
          state_nxt.addr = req_addr;
          state_nxt.wr   = req_wr;
          state_nxt.d_o  = req_wdata;
          state_nxt.d_oe = req_wr;
          // in the data strobe scheme the direction is set up before the strobe
          // use the scheme being latched now, not the one of the previous access
          state_nxt.dir  = (scheme_cfg == DATA_STROBE_SCHEME) ? ~req_wr : 1'b1;
        end
      end
      DMUPH_SETUP: begin
        state_nxt.st   = DMUPH_ASSERT;
        // select a cycle after the scheme pin moved, so it is steady while selected
        state_nxt.cs_n = 1'b0;
        if (state_r.scheme == DATA_STROBE_SCHEME) begin
          state_nxt.strobe_n = 1'b0;
        end else if (state_r.wr) begin
          state_nxt.dir = 1'b0;
        end else begin
          state_nxt.strobe_n = 1'b0;
        end
      end
      DMUPH_ASSERT: begin
        // one cycle for the device to leave its idle ready level
        state_nxt.st = DMUPH_WAIT;
      end
      DMUPH_WAIT: begin
        if (hs_ready) begin
          state_nxt.st       = DMUPH_RELEASE;
          state_nxt.rdata    = state_r.wr ? state_r.rdata : port.data_bus;
          state_nxt.strobe_n = 1'b1;
          state_nxt.dir      = 1'b1;
        end
      end
      DMUPH_RELEASE: begin
        state_nxt.st   = DMUPH_IDLE;
        state_nxt.cs_n = 1'b1;
        state_nxt.d_oe = 1'b0;
        state_nxt.done = 1'b1;
      end
      default: begin
        state_nxt.st = DMUPH_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r.st       <= DMUPH_IDLE;
      state_r.scheme   <= SPLIT_STROBE_SCHEME;
      state_r.cs_n     <= 1'b1;
      state_r.addr     <= '0;
      state_r.strobe_n <= 1'b1;
      state_r.dir      <= 1'b1;
      state_r.d_o      <= LOC_RESET;
      state_r.d_oe     <= 1'b0;
      state_r.wr       <= 1'b0;
      state_r.done     <= 1'b0;
      state_r.rdata    <= LOC_RESET;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // all pins come straight from flops
  assign port.scheme_sel      = state_r.scheme;
  assign port.cs_n            = state_r.cs_n;
  assign port.addr            = state_r.addr;
  assign port.shared_strobe_n = state_r.strobe_n;
  assign port.dir_wr          = state_r.dir;
  assign port.host_d_o        = state_r.d_o;
  assign port.host_d_oe       = state_r.d_oe;
  assign busy                 = (state_r.st != DMUPH_IDLE);
  assign done                 = state_r.done;
  assign rdata                = state_r.rdata;
endmodule
`default_nettype wire

/* File: pkg/dmup_pkg.sv */
`default_nettype none
// shared constants for both ends of the configuration microport
package dmup_pkg;
  // bus widths
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int ID_W   = 4;
  localparam int CNT_W  = 4;

  // scheme select pin levels
  localparam logic SPLIT_STROBE_SCHEME = 1'b0;
  localparam logic DATA_STROBE_SCHEME  = 1'b1;

  // direction pin level for a read in the data strobe scheme
  localparam logic DIR_READ = 1'b1;

  // access timing: documented ceiling and the latency actually used
  localparam int CLK_PERIOD_NS = 10;
  localparam int ACC_MAX_CYC   = 9;
  localparam logic [CNT_W-1:0] ACC_CYC = 4'h4;

  // access control location and its identity field
  localparam logic [ADDR_W-1:0] ACR_ADDR = 3'h7;
  localparam int ACR_ID_LSB = 2;
  localparam int ACR_ID_MSB = 5;

  // reset values
  localparam logic [DATA_W-1:0] LOC_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] BUS_IDLE   = 8'hff;
  localparam logic [CNT_W-1:0]  CNT_ZERO   = 4'h0;
  localparam logic [CNT_W-1:0]  CNT_ONE    = 4'h1;
  localparam int                NUM_LOC    = 8;
endpackage
`default_nettype wire

/* File: pkg/dmup_if.sv */
`default_nettype none
// microport pins between the host and the device
interface dmup_if;
  import dmup_pkg::*;
  logic              scheme_sel;        // mode select, driven by host
  logic              cs_n;              // chip select, active low
  logic [ADDR_W-1:0] addr;              // location select
  logic              shared_strobe_n;   // data strobe or read strobe
  logic              dir_wr;            // read/write select or write strobe (low)
  logic              handshake_out;     // acknowledge (low) or ready (high)
  logic [DATA_W-1:0] host_d_o;
  logic              host_d_oe;
  logic [DATA_W-1:0] dev_d_o;
  logic              dev_d_oe;
  logic [DATA_W-1:0] data_bus;          // resolved wire level

  // bus level from the enables; an undriven bus floats high on its pull-ups
  assign data_bus = dev_d_oe ? dev_d_o : (host_d_oe ? host_d_o : BUS_IDLE);

  modport device (
    input  scheme_sel, cs_n, addr, shared_strobe_n, dir_wr, data_bus,
    output handshake_out, dev_d_o, dev_d_oe
  );
  modport host (
    output scheme_sel, cs_n, addr, shared_strobe_n, dir_wr, host_d_o, host_d_oe,
    input  handshake_out, data_bus
  );
endinterface
`default_nettype wire

/* File: verilog/dmup_device.sv */
// Behaviour
// - scheme pin: 0 split strobes, 1 data strobe
// - host drives shared strobe per selected scheme
// - handshake is acknowledge or ready by scheme
// - direction pin is select or write strobe
// - chip select high releases the data bus
// - three address lines pick a location
// - one shared eight-bit data bus both ways
// - split-scheme ready within nine clocks of strobe
// - identity pins match access control bits 5..2
`default_nettype none
module dmup_device (
  input  wire logic                       mclk,
  input  wire logic                       srst,
  input  wire logic                       ce,
  input  wire logic [dmup_pkg::ID_W-1:0]  device_identity_select,
  dmup_if.device                          port,
  output logic [dmup_pkg::DATA_W-1:0]     acr_value,
  output logic                            access_hit,
  output logic                            write_pulse
);
  import dmup_pkg::*;

  typedef enum logic [1:0] {
    DMUP_IDLE,
    DMUP_BUSY,
    DMUP_DONE
  } dmup_dev_state_e;

  typedef struct packed {
    dmup_dev_state_e                 st;
    logic [CNT_W-1:0]                cnt;
    logic                            is_wr;
    logic                            hit;
    logic [ADDR_W-1:0]               loc;
    logic [DATA_W-1:0]               rd_data;
    logic                            wr_pulse;
    logic [NUM_LOC-1:0][DATA_W-1:0]  mem;
  } dmup_dev_s;

  dmup_dev_s state_r;
  dmup_dev_s state_nxt;

  logic data_scheme;
  logic strobe_act;
  logic strobe_rd;
  logic id_match;

  // decode the shared pins by scheme
  always_comb begin
    data_scheme = (port.scheme_sel == DATA_STROBE_SCHEME);
    if (data_scheme) begin
      // data strobe frames the access, direction pin names it
      strobe_act = ~port.shared_strobe_n;
      strobe_rd  = (port.dir_wr == DIR_READ);
    end else begin
      // separate active-low read and write strobes
      strobe_act = ~port.shared_strobe_n | ~port.dir_wr;
      strobe_rd  = ~port.shared_strobe_n;
    end
  end

  // identity pins against the stored field of the access control location
  assign id_match = (state_r.mem[ACR_ADDR][ACR_ID_MSB:ACR_ID_LSB]
                     == device_identity_select);

  // next-state logic of the whole port
  always_comb begin
    state_nxt          = state_r;
    state_nxt.wr_pulse = 1'b0;
    case (state_r.st)
      DMUP_IDLE: begin
        // an access starts on chip select with an active strobe
        if (!port.cs_n && strobe_act) begin
          state_nxt.st    = DMUP_BUSY;
          state_nxt.cnt   = ACC_CYC - CNT_ONE;
          state_nxt.is_wr = ~strobe_rd;
          state_nxt.loc   = port.addr;
          // the access control location is always reachable so the match can be set up
          state_nxt.hit   = id_match || (port.addr == ACR_ADDR);
        end
      end
      DMUP_BUSY: begin
        if (port.cs_n || !strobe_act) begin
          // host gave up early: drop the access, nothing is stored
          state_nxt.st = DMUP_IDLE;
        end else if (state_r.cnt == CNT_ZERO) begin
          // fixed latency keeps ready well inside nine clocks
          state_nxt.st = DMUP_DONE;
          if (state_r.hit) begin
            if (state_r.is_wr) begin
              // write data is taken at the end, when the host has settled it
              state_nxt.mem[state_r.loc] = port.data_bus;
              state_nxt.wr_pulse         = 1'b1;
            end else begin
              state_nxt.rd_data = state_r.mem[state_r.loc];
            end
          end
        end else begin
          state_nxt.cnt = state_r.cnt - CNT_ONE;
        end
      end
      DMUP_DONE: begin
        // hold the handshake until the strobe is released
        if (!strobe_act || port.cs_n) begin
          state_nxt.st = DMUP_IDLE;
        end
      end
      default: begin
        state_nxt.st = DMUP_IDLE;
      end
    endcase
  end

  // state register; clock enable freezes everything
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r.st       <= DMUP_IDLE;
      state_r.cnt      <= CNT_ZERO;
      state_r.is_wr    <= 1'b0;
      state_r.hit      <= 1'b0;
      state_r.loc      <= '0;
      state_r.rd_data  <= LOC_RESET;
      state_r.wr_pulse <= 1'b0;
      state_r.mem      <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // handshake: ready is high except while busy; acknowledge low once done
  always_comb begin
    if (data_scheme) begin
      port.handshake_out = ~(state_r.st == DMUP_DONE);
    end else begin
      port.handshake_out = (state_r.st != DMUP_BUSY);
    end
  end

  // read data is registered; enable is combinational so release is immediate
  assign port.dev_d_o  = state_r.rd_data;
  assign port.dev_d_oe = !port.cs_n
                         && strobe_act && !state_r.is_wr && state_r.hit
                         && (state_r.st == DMUP_DONE);

  // user-side view of the stored configuration
  assign acr_value   = state_r.mem[ACR_ADDR];
  assign access_hit  = state_r.hit;
  assign write_pulse = state_r.wr_pulse;
endmodule
`default_nettype wire

/* File: verification/dmup_asserts.sv */
`default_nettype none
// watches the microport wires between the host end and the device end
module dmup_asserts (
  input wire logic                        mclk,
  input wire logic                        srst,
  input wire logic                        scheme_sel,
  input wire logic                        cs_n,
  input wire logic [dmup_pkg::ADDR_W-1:0] addr,
  input wire logic                        shared_strobe_n,
  input wire logic                        dir_wr,
  input wire logic                        handshake_out,
  input wire logic                        host_d_oe,
  input wire logic                        dev_d_oe
);
  import dmup_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // bus ownership: only one end drives, the device only in a selected read
  a_cs_release: assert property (cs_n |-> !dev_d_oe)
    else $error("device drives bus while deselected");
  a_drive_read: assert property (dev_d_oe |-> !cs_n && !shared_strobe_n
      && (scheme_sel ? dir_wr == DIR_READ : dir_wr))
    else $error("device drives bus outside a read strobe");
  a_one_driver: assert property (!(dev_d_oe && host_d_oe))
    else $error("both ends drive the data bus");
  a_write_data: assert property (!scheme_sel && !cs_n && !dir_wr |-> host_d_oe)
    else $error("write strobe without host data");

  // handshake meaning per scheme; take is the edge the strobe is first seen
  a_ready_busy: assert property (!scheme_sel && !cs_n && $fell(shared_strobe_n) |=> !handshake_out)
    else $error("ready not dropped after read strobe");
  a_split_ready: assert property (!scheme_sel && !cs_n
      && ($fell(shared_strobe_n) || $fell(dir_wr)) |-> ##[1:9] $rose(handshake_out))
    else $error("ready later than nine clocks");
  a_ack_low: assert property (scheme_sel && !cs_n && $fell(shared_strobe_n)
      |-> ##[1:9] !handshake_out)
    else $error("acknowledge missing");
  a_ack_release: assert property (scheme_sel && $rose(shared_strobe_n) |=> handshake_out)
    else $error("acknowledge held after strobe release");

  // host keeps scheme and address steady through an access
  a_scheme_stable: assert property (!cs_n |-> $stable(scheme_sel))
    else $error("scheme changed during access");
  a_addr_stable: assert property (!cs_n && !$fell(cs_n) |-> $stable(addr))
    else $error("address changed during access");
  a_strobe_cs: assert property (!shared_strobe_n |-> !cs_n)
    else $error("strobe without chip select");

  c_split_done: cover property (!scheme_sel && $rose(handshake_out));
  c_ack_done: cover property (scheme_sel && $fell(handshake_out));
  c_dev_drive: cover property (dev_d_oe);
endmodule
`default_nettype wire

/* File: verification/dual_mode_microport_pins_test.sv */
`default_nettype none
module dual_mode_microport_pins_test;
  import dmup_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk, srst, scheme_cfg, req, req_wr, busy, done, hit, wp;
  logic [2:0]  req_addr;
  logic [7:0]  req_wdata, rdata, acr_value, mem [8];
  logic [3:0]  id_sel;
  logic [8:0]  expq [$];
  logic [8:0]  nt;
  logic [31:0] rs;
  int          err_count, cmp_count, i, s, wp_count;
  dmup_if bus_if ();
  dmup_device u_dmup_device (.mclk(mclk), .srst(srst), .ce(1'h1),
    .device_identity_select(id_sel), .port(bus_if), .acr_value(acr_value),
    .access_hit(hit), .write_pulse(wp));
  dmup_host u_dmup_host (.mclk(mclk), .srst(srst), .ce(1'h1), .scheme_cfg(scheme_cfg),
    .req(req), .req_wr(req_wr), .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy),
    .done(done), .rdata(rdata), .port(bus_if));
  dmup_asserts u_chk (.mclk(mclk), .srst(srst), .scheme_sel(bus_if.scheme_sel),
    .cs_n(bus_if.cs_n), .addr(bus_if.addr), .shared_strobe_n(bus_if.shared_strobe_n),
    .dir_wr(bus_if.dir_wr), .handshake_out(bus_if.handshake_out),
    .host_d_oe(bus_if.host_d_oe), .dev_d_oe(bus_if.dev_d_oe));

  // 100 MHz clock
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] v);
    cmp_count++;
    if (v !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, v);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // one access; the note queued is {read, expected byte}
  task automatic op(input logic w, input logic [2:0] a, input logic [7:0] d,
                    input logic [7:0] e);
    int n;
    n = 0;
    expq.push_back({~w, e});
    req = 1'h1;
    req_wr = w;
    req_addr = a;
    req_wdata = d;
    @(posedge mclk);
    #1 req = 1'h0;
    while (done !== 1'h1 && n < 40) begin
      @(posedge mclk);
      #1 n++;
    end
    // a host that never finishes is a failure, not a silent skip
    if (n >= 40) err_count++;
    @(posedge mclk);
    #1;
  endtask

  // result watcher: done pulse settles after the edge, bus must float once deselected
  always @(posedge mclk) begin
    #2;
    // count stored writes; a dropped write must leave no pulse
    if (wp === 1'h1) wp_count++;
    if (done === 1'h1) begin
      nt = expq.pop_front();
      if (nt[8]) chk("rdata", nt[7:0], rdata);
      chk("idle bus", BUS_IDLE, bus_if.data_bus);
    end
  end

  // watchdog sized well beyond the thirty-one accesses of the run
  initial begin
    #100000;
    err_count++;
    stop_test();
  end

  initial begin
    rs = 32'h26;
    wp_count = 0;
    srst = 1'h1;
    req = 1'h0;
    req_wr = 1'h0;
    req_addr = 3'h0;
    req_wdata = 8'h00;
    scheme_cfg = 1'h0;
    id_sel = 4'h0;
    for (i = 0; i < 8; i++) mem[i] = 8'h00;
    repeat (6) @(posedge mclk);
    #1 srst = 1'h0;
    // both schemes, random locations and data, back to back
    for (s = 0; s < 2; s++) begin
      scheme_cfg = s[0];
      op(1'h0, ACR_ADDR, 8'h00, mem[7]);
      for (i = 0; i < 6; i++) begin
        req_addr = 3'(xs() % 7);
        req_wdata = 8'(xs()) & 8'hc3;
        mem[req_addr] = req_wdata;
        op(1'h1, req_addr, req_wdata, 8'h00);
        op(1'h0, req_addr, 8'h00, mem[req_addr]);
      end
    end
    // identity mismatch: write dropped, read left floating, location 7 open
    scheme_cfg = 1'h0;
    op(1'h1, ACR_ADDR, 8'h14, 8'h00);
    chk("acr", 8'h14, acr_value);
    op(1'h1, 3'h2, 8'h5a, 8'h00);
    op(1'h0, 3'h2, 8'h00, BUS_IDLE);
    scheme_cfg = 1'h1;
    op(1'h0, ACR_ADDR, 8'h00, 8'h14);
    id_sel = 4'h5;
    op(1'h0, 3'h2, 8'h00, mem[2]);
    repeat (4) @(posedge mclk);
    // twelve random writes and the access control write; the mismatched one is dropped
    chk("writes stored", 8'h0d, 8'(wp_count));
    stop_test();
  end
endmodule
`default_nettype wire
